// >>> gip_consts.svh
// register offsets, field positions, bus command codes and timing figures
`ifndef GIP_CONSTS_SVH
`define GIP_CONSTS_SVH
// ****************************************
// register map (byte addresses)
// ****************************************
`define GIP_OFS_CTRL 5'h00
`define GIP_OFS_STAT 5'h04
`define GIP_OFS_TX 5'h08
`define GIP_OFS_RX 5'h0C
`define GIP_OFS_EVT 5'h10
`define GIP_OFS_SPOLL 5'h14
`define GIP_CTRL_RST 1'h0
`define GIP_CTRL_GET_BIT 0
`define GIP_EOI_BIT 8
`define GIP_RXV_BIT 9
`define GIP_EVT_GET 0
`define GIP_EVT_CLR 1
`define GIP_EVT_BTN 2
`define GIP_EVT_IFC 3
`define GIP_SP_RSV 6
`define GIP_SP_ERR 5
// ****************************************
// addressing and bus commands (7-bit)
// ****************************************
`define GIP_ADDR_DFLT 5'h06
`define GIP_MLA_BASE 7'h20
`define GIP_MTA_BASE 7'h40
`define GIP_GRP_MASK 7'h60
`define GIP_CMD_UNL 7'h3F
`define GIP_CMD_UNT 7'h5F
`define GIP_CMD_GTL 7'h01
`define GIP_CMD_SDC 7'h04
`define GIP_CMD_GET 7'h08
`define GIP_CMD_LLO 7'h11
`define GIP_CMD_DCL 7'h14
`define GIP_CMD_SPE 7'h18
`define GIP_CMD_SPD 7'h19
// ****************************************
// timing
// ****************************************
`define GIP_CLK_NS 40
`define GIP_SETTLE_NS 2000
`define GIP_BLINK_MS 100
`endif

// >>> gip_ctl_model.sv
// behavioural bus controller and talking and listening partner for the instrument port
`timescale 1ns/100ps
module gip_ctl_model (
  input wire logic core_clk,
  input wire logic [7:0] dio,
  input wire logic dav,
  input wire logic nrfd,
  input wire logic ndac,
  input wire logic eoi,
  output logic [7:0] dio_oe,
  output logic dav_oe,
  output logic nrfd_oe,
  output logic ndac_oe,
  output logic atn_oe
);
  initial
  begin
    dio_oe = 8'h00;
    dav_oe = 1'b0;
    nrfd_oe = 1'b0;
    ndac_oe = 1'b0;
    atn_oe = 1'b0;
  end
  // ****************************************
  // source side: one byte, command when atn set
  // ****************************************
  // lines are sampled right at the rising edge, where they have settled
  task send(input logic atn, input logic [7:0] b);
    @(posedge core_clk);
    atn_oe <= atn;
    nrfd_oe <= 1'b0;
    ndac_oe <= 1'b0;
    dio_oe <= b;
    repeat (3) @(posedge core_clk);
    while (!(nrfd === 1'b1 && ndac === 1'b0)) @(posedge core_clk);
    dav_oe <= 1'b1;
    @(posedge core_clk);
    while (ndac !== 1'b1) @(posedge core_clk);
    dav_oe <= 1'b0;
    dio_oe <= 8'h00;
    @(posedge core_clk);
    while (ndac !== 1'b0) @(posedge core_clk);
  endtask : send
  task release_atn();
    @(posedge core_clk);
    atn_oe <= 1'b0;
  endtask : release_atn
  // ****************************************
  // acceptor side; slow stretches the not-ready time
  // ****************************************
  task recv(input int slow, output logic [7:0] b, output logic e);
    @(posedge core_clk);
    atn_oe <= 1'b0;
    ndac_oe <= 1'b1;
    nrfd_oe <= 1'b1;
    repeat (slow + 1) @(posedge core_clk);
    nrfd_oe <= 1'b0;
    @(posedge core_clk);
    while (dav !== 1'b0) @(posedge core_clk);
    b = ~dio;
    e = ~eoi;
    nrfd_oe <= 1'b1;
    ndac_oe <= 1'b0;
    @(posedge core_clk);
    while (dav !== 1'b1) @(posedge core_clk);
    ndac_oe <= 1'b1;
    nrfd_oe <= 1'b0;
  endtask : recv
endmodule : gip_ctl_model

// >>> gip_pkg.sv
// state types of the bus handshakes
package gip_pkg;
  typedef enum logic [1:0] {GIP_SH_IDLE, GIP_SH_SETTLE, GIP_SH_DAV} gip_sh_t;
  typedef enum logic [0:0] {GIP_AH_IDLE, GIP_AH_ACC} gip_ah_t;
endpackage : gip_pkg

// >>> gip_port.sv
// bus instrument port: handshakes, addressing, remote/local, registers
`timescale 1ns/100ps
`include "gip_consts.svh"

module gip_port #(
  parameter int unsigned BLINK_CYC = `GIP_BLINK_MS * 1000000 / `GIP_CLK_NS
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] sw_on,
  input wire logic btn_press,
  input wire logic [7:0] dio_i,
  output logic [7:0] dio_o,
  output logic [7:0] dio_oe,
  input wire logic dav_i,
  output logic dav_o,
  output logic dav_oe,
  input wire logic nrfd_i,
  output logic nrfd_o,
  output logic nrfd_oe,
  input wire logic ndac_i,
  output logic ndac_o,
  output logic ndac_oe,
  input wire logic eoi_i,
  output logic eoi_o,
  output logic eoi_oe,
  input wire logic srq_i,
  output logic srq_o,
  output logic srq_oe,
  input wire logic atn_n,
  input wire logic ifc_n,
  input wire logic ren_n,
  output logic meas_trig,
  output logic ind_remote,
  output logic ind_listen,
  output logic ind_talk,
  output logic ind_lockout
);
  localparam int unsigned SETTLE_CYC = (`GIP_SETTLE_NS + `GIP_CLK_NS - 1) / `GIP_CLK_NS;

  // ****************************************
  // bus line levels (low = asserted)
  // ****************************************
  logic atn_a, ifc_a, ren_a, dav_a, nrfd_a, ndac_a;
  logic [7:0] dio_a;
  assign atn_a = ~atn_n;
  assign ifc_a = ~ifc_n;
  assign ren_a = ~ren_n;
  assign dav_a = ~dav_i;
  assign nrfd_a = ~nrfd_i;
  assign ndac_a = ~ndac_i;
  assign dio_a = ~dio_i;

  // ****************************************
  // state
  // ****************************************
  logic cfg_done_r, addr_mode_r;
  logic [4:0] addr_r;
  logic tad_r, lad_r, spe_r, remote_r, lockout_r;
  logic ctrl_get_r;
  logic [7:0] tx_r;
  logic tx_eoi_r, tx_full_r;
  logic [7:0] rx_r;
  logic rx_eoi_r, rx_valid_r;
  logic [3:0] evt_r;
  logic [7:0] spoll_r;
  logic to_busy_r, meas_trig_r;
  logic [21:0] blink_r;
  logic [5:0] settle_r;
  logic rd_ack_r;
  logic [31:0] rdata_r;
  gip_pkg::gip_sh_t sh_r;
  gip_pkg::gip_ah_t ah_r;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_addr(input logic [6:0] b, input logic [6:0] base);
    is_addr = (b & `GIP_GRP_MASK) == base;
  endfunction : is_addr

  logic talker_only, talk_act, ah_act, ah_ready, acc_take, cmd_take, data_take;
  logic [6:0] cmd;
  logic sh_done, send_sp, bus_clear, get_trig, btn_ok;
  logic avs_hit_wr, tx_wr, evt_wr, rx_rd;
  logic [7:0] src_byte;

  assign talker_only = cfg_done_r && !addr_mode_r;
  assign talk_act = (talker_only || tad_r) && !atn_a;
  assign send_sp = spe_r && tad_r;
  assign src_byte = send_sp ? {spoll_r[7], spoll_r[`GIP_SP_RSV], spoll_r[5:0]} : tx_r;
  assign ah_act = cfg_done_r && (atn_a || lad_r);
  assign ah_ready = atn_a || !rx_valid_r;
  assign acc_take = ah_act && (ah_r == gip_pkg::GIP_AH_IDLE) && dav_a && ah_ready;
  assign cmd = dio_a[6:0];
  assign cmd_take = acc_take && atn_a && addr_mode_r;
  assign data_take = acc_take && !atn_a && lad_r;
  assign sh_done = (sh_r == gip_pkg::GIP_SH_DAV) && !ndac_a && talk_act;
  assign bus_clear = cmd_take && lad_r && (cmd == `GIP_CMD_SDC)
    || cmd_take && (cmd == `GIP_CMD_DCL);
  assign get_trig = cmd_take && lad_r && (cmd == `GIP_CMD_GET) && ctrl_get_r;
  assign btn_ok = btn_press && !lockout_r && cfg_done_r;

  // ****************************************
  // power-up switch capture
  // ****************************************
  // switches are sampled once, first enabled edge after reset release
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_done_r <= 1'b0;
      addr_mode_r <= 1'b0;
      addr_r <= `GIP_ADDR_DFLT;
    end
    else if (clk_en && !cfg_done_r)
    begin
      cfg_done_r <= 1'b1;
      addr_mode_r <= sw_on[0];
      // off switches add weight; position 4 weighs 16, position 8 weighs 1
      if (~{sw_on[3], sw_on[4], sw_on[5], sw_on[6], sw_on[7]} == 5'h00)
        addr_r <= `GIP_ADDR_DFLT;
      else
        addr_r <= ~{sw_on[3], sw_on[4], sw_on[5], sw_on[6], sw_on[7]};
    end
  end

  // ****************************************
  // addressing, serial poll, remote/local
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tad_r <= 1'b0;
      lad_r <= 1'b0;
      spe_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ifc_a)
      begin
        tad_r <= 1'b0;
        lad_r <= 1'b0;
        spe_r <= 1'b0;
      end
      else if (cmd_take)
      begin
        if (cmd == (`GIP_MLA_BASE | {2'h0, addr_r}))
          lad_r <= 1'b1;
        else if (cmd == `GIP_CMD_UNL)
          lad_r <= 1'b0;
        if (cmd == (`GIP_MTA_BASE | {2'h0, addr_r}))
          tad_r <= 1'b1;
        else if (is_addr(cmd, `GIP_MTA_BASE))
          tad_r <= 1'b0;
        if (cmd == `GIP_CMD_SPE)
          spe_r <= 1'b1;
        else if (cmd == `GIP_CMD_SPD)
          spe_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      remote_r <= 1'b0;
      lockout_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!ren_a)
      begin
        remote_r <= 1'b0;
        lockout_r <= 1'b0;
      end
      else if (cmd_take)
      begin
        if (cmd == (`GIP_MLA_BASE | {2'h0, addr_r}))
          remote_r <= 1'b1;
        else if (cmd == `GIP_CMD_GTL && lad_r)
          remote_r <= 1'b0;
        if (cmd == `GIP_CMD_LLO)
          lockout_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // acceptor handshake
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ah_r <= gip_pkg::GIP_AH_IDLE;
    else if (clk_en)
    begin
      unique case (ah_r)
        gip_pkg::GIP_AH_IDLE:
          if (acc_take)
            ah_r <= gip_pkg::GIP_AH_ACC;
        gip_pkg::GIP_AH_ACC:
          if (!dav_a || !ah_act)
            ah_r <= gip_pkg::GIP_AH_IDLE;
      endcase
    end
  end

  // ****************************************
  // source handshake
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sh_r <= gip_pkg::GIP_SH_IDLE;
      settle_r <= 6'h00;
    end
    else if (clk_en)
    begin
      if (!talk_act)
        sh_r <= gip_pkg::GIP_SH_IDLE; // attention pre-empts the talker
      else
      begin
        unique case (sh_r)
          gip_pkg::GIP_SH_IDLE:
            if (send_sp || tx_full_r)
            begin
              sh_r <= gip_pkg::GIP_SH_SETTLE;
              settle_r <= 6'h00;
            end
          gip_pkg::GIP_SH_SETTLE:
            if (settle_r < 6'(SETTLE_CYC - 1))
              settle_r <= settle_r + 6'h01;
            else if (!nrfd_a && ndac_a)
              sh_r <= gip_pkg::GIP_SH_DAV;
          gip_pkg::GIP_SH_DAV:
            if (!ndac_a)
              sh_r <= gip_pkg::GIP_SH_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // pin drivers: pull low or release
  // ****************************************
  assign dio_o = 8'h00;
  assign dav_o = 1'b0;
  assign nrfd_o = 1'b0;
  assign ndac_o = 1'b0;
  assign eoi_o = 1'b0;
  assign srq_o = 1'b0;
  // data only while talking and attention is off, so no data is driven under attention
  assign dio_oe = (talk_act && sh_r != gip_pkg::GIP_SH_IDLE) ? src_byte : 8'h00;
  assign dav_oe = talk_act && (sh_r == gip_pkg::GIP_SH_DAV);
  assign eoi_oe = talk_act && (sh_r != gip_pkg::GIP_SH_IDLE) && !send_sp && tx_eoi_r;
  assign nrfd_oe = ah_act && ((ah_r == gip_pkg::GIP_AH_ACC) || !ah_ready);
  assign ndac_oe = ah_act && (ah_r == gip_pkg::GIP_AH_IDLE);
  assign srq_oe = spoll_r[`GIP_SP_RSV] && addr_mode_r;

  // ****************************************
  // register bus
  // ****************************************
  // writes to a full transmit register stall instead of overwriting
  assign tx_wr = avs_write && avs_address == `GIP_OFS_TX;
  // a frozen core can neither store a write nor finish a read: hold the master off
  assign avs_waitrequest = (!clk_en && (avs_read || avs_write)) || (avs_read && !rd_ack_r)
    || (tx_wr && tx_full_r);
  assign avs_hit_wr = avs_write && !avs_waitrequest;
  assign evt_wr = avs_hit_wr && avs_address == `GIP_OFS_EVT;
  assign rx_rd = avs_read && rd_ack_r && avs_address == `GIP_OFS_RX;
  assign avs_readdata = rdata_r;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      rd_ack_r <= avs_read && !rd_ack_r;
      if (avs_read && !rd_ack_r)
      begin
        unique case (avs_address)
          `GIP_OFS_CTRL: rdata_r <= {31'h0000_0000, ctrl_get_r};
          `GIP_OFS_STAT: rdata_r <= {19'h0_0000, to_busy_r, tx_full_r, addr_r,
            lockout_r, remote_r, spe_r, lad_r, tad_r, addr_mode_r};
          `GIP_OFS_TX: rdata_r <= {23'h00_0000, tx_eoi_r, tx_r};
          `GIP_OFS_RX: rdata_r <= {22'h00_0000, rx_valid_r, rx_eoi_r, rx_r};
          `GIP_OFS_EVT: rdata_r <= {28'h000_0000, evt_r};
          `GIP_OFS_SPOLL: rdata_r <= {24'h00_0000, spoll_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_get_r <= `GIP_CTRL_RST;
    else if (clk_en)
    begin
      if (bus_clear)
        ctrl_get_r <= `GIP_CTRL_RST;
      else if (avs_hit_wr && avs_address == `GIP_OFS_CTRL)
        ctrl_get_r <= avs_writedata[`GIP_CTRL_GET_BIT];
    end
  end

  // rsv is dropped once the status byte has gone out on a poll
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      spoll_r <= 8'h00;
    else if (clk_en)
    begin
      if (bus_clear)
        spoll_r <= 8'h00;
      else if (avs_hit_wr && avs_address == `GIP_OFS_SPOLL)
        spoll_r <= avs_writedata[7:0];
      else if (sh_done && send_sp)
        spoll_r[`GIP_SP_RSV] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_r <= 8'h00;
      tx_eoi_r <= 1'b0;
      tx_full_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (avs_hit_wr && tx_wr)
      begin
        tx_r <= avs_writedata[7:0];
        tx_eoi_r <= avs_writedata[`GIP_EOI_BIT];
        tx_full_r <= 1'b1;
      end
      else if (sh_done && !send_sp)
        tx_full_r <= 1'b0;
    end
  end

  // received byte stays until software reads it; a new byte wins a same-cycle read
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_r <= 8'h00;
      rx_eoi_r <= 1'b0;
      rx_valid_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (data_take)
      begin
        rx_r <= dio_a;
        rx_eoi_r <= ~eoi_i;
        rx_valid_r <= 1'b1;
      end
      else if (rx_rd)
        rx_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      evt_r <= 4'h0;
    else if (clk_en)
      evt_r <= (evt_r & ~(evt_wr ? avs_writedata[3:0] : 4'h0))
        | {ifc_a, btn_ok, bus_clear, get_trig};
  end

  // ****************************************
  // triggers, talker-only cycle, indicators
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meas_trig_r <= 1'b0;
      to_busy_r <= 1'b0;
      blink_r <= 22'h00_0000;
    end
    else if (clk_en)
    begin
      meas_trig_r <= get_trig || (btn_ok && talker_only && !to_busy_r);
      if (talker_only && btn_ok && !to_busy_r)
        to_busy_r <= 1'b1;
      else if (talker_only && sh_done && tx_eoi_r)
        to_busy_r <= 1'b0;
      if (talker_only && sh_done && tx_eoi_r)
        blink_r <= 22'(BLINK_CYC);
      else if (blink_r != 22'h00_0000)
        blink_r <= blink_r - 22'h00_0001;
    end
  end

  assign meas_trig = meas_trig_r;
  assign ind_remote = remote_r;
  assign ind_listen = lad_r || (blink_r != 22'h00_0000);
  assign ind_talk = talker_only || tad_r;
  assign ind_lockout = lockout_r;

  // ****************************************
  // assertions
  // ****************************************
  property p_addr_range;
    @(posedge core_clk) disable iff (!arst_n)
    cfg_done_r |-> addr_r != 5'h00;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("primary address is zero");

  property p_talk_only_ind;
    @(posedge core_clk) disable iff (!arst_n)
    talker_only |-> ind_talk && !tad_r;
  endproperty
  a_talk_only_ind: assert property (p_talk_only_ind) else $error("talk indicator off");

  property p_no_poll_drive;
    @(posedge core_clk) disable iff (!arst_n)
    atn_a |-> dio_oe == 8'h00 && !eoi_oe;
  endproperty
  a_no_poll_drive: assert property (p_no_poll_drive) else $error("data driven under attention");

  property p_dav_when_ready;
    @(posedge core_clk) disable iff (!arst_n)
    $rose(dav_oe) |-> $past(!nrfd_a) && $past(sh_r == gip_pkg::GIP_SH_SETTLE);
  endproperty
  a_dav_when_ready: assert property (p_dav_when_ready) else $error("valid set while not ready");

  property p_lockout_btn;
    @(posedge core_clk) disable iff (!arst_n)
    clk_en && lockout_r && btn_press && !get_trig |=> !meas_trig;
  endproperty
  a_lockout_btn: assert property (p_lockout_btn) else $error("button acted under lockout");

  property p_send_addressed;
    @(posedge core_clk) disable iff (!arst_n)
    dio_oe != 8'h00 |-> (tad_r || to_busy_r || talker_only) && !atn_a;
  endproperty
  a_send_addressed: assert property (p_send_addressed) else $error("sent while not talker");

  property p_listen_data;
    @(posedge core_clk) disable iff (!arst_n)
    clk_en && data_take |=> rx_valid_r && $past(lad_r) && $past(!atn_a);
  endproperty
  a_listen_data: assert property (p_listen_data) else $error("data taken unaddressed");

  property p_ren_release;
    @(posedge core_clk) disable iff (!arst_n)
    clk_en && !ren_a |=> !lockout_r && !ind_remote;
  endproperty
  a_ren_release: assert property (p_ren_release) else $error("lockout kept without remote");

  property p_dav_hold;
    @(posedge core_clk) disable iff (!arst_n)
    clk_en && dav_oe && ndac_a && !atn_a && !ifc_a |=> dav_oe || atn_a;
  endproperty
  a_dav_hold: assert property (p_dav_hold) else $error("valid dropped before accept");
endmodule : gip_port

// >>> gip_port_bench.sv
// self-checking bench of the bus instrument port
`timescale 1ns/100ps
module gip_port_bench;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] sw_on = 8'h00;
  logic btn_press = 1'b0;
  logic ren_n = 1'b1;
  logic clk_en = 1'b1;
  logic ifc_n = 1'b1;
  logic [7:0] dio_o, dio_oe, m_dio_oe;
  logic dav_o, dav_oe, nrfd_o, nrfd_oe, ndac_o, ndac_oe, eoi_o, eoi_oe, srq_o, srq_oe;
  logic m_dav_oe, m_nrfd_oe, m_ndac_oe, m_atn_oe;
  logic meas_trig, ind_remote, ind_listen, ind_talk, ind_lockout;
  wire logic [7:0] dio = ~(dio_oe | m_dio_oe);
  wire logic dav = !(dav_oe || m_dav_oe);
  wire logic nrfd = !(nrfd_oe || m_nrfd_oe);
  wire logic ndac = !(ndac_oe || m_ndac_oe);
  wire logic eoi = !eoi_oe;
  wire logic srq = !srq_oe;
  int error_cnt = 0;
  int num_checks = 0;
  int trig_cnt = 0;
  logic [31:0] seed = 32'h0000_C9D0;
  logic [31:0] q;
  logic [7:0] b, rb;
  logic [4:0] addr;
  logic e;

  gip_port #(.BLINK_CYC(20)) dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sw_on(sw_on), .btn_press(btn_press),
    .dio_i(dio), .dio_o(dio_o), .dio_oe(dio_oe), .dav_i(dav), .dav_o(dav_o), .dav_oe(dav_oe),
    .nrfd_i(nrfd), .nrfd_o(nrfd_o), .nrfd_oe(nrfd_oe), .ndac_i(ndac), .ndac_o(ndac_o),
    .ndac_oe(ndac_oe), .eoi_i(eoi), .eoi_o(eoi_o), .eoi_oe(eoi_oe), .srq_i(srq),
    .srq_o(srq_o), .srq_oe(srq_oe), .atn_n(!m_atn_oe), .ifc_n(ifc_n), .ren_n(ren_n),
    .meas_trig(meas_trig), .ind_remote(ind_remote), .ind_listen(ind_listen),
    .ind_talk(ind_talk), .ind_lockout(ind_lockout));

  gip_ctl_model ctl (.core_clk(core_clk), .dio(dio), .dav(dav), .nrfd(nrfd), .ndac(ndac),
    .eoi(eoi), .dio_oe(m_dio_oe), .dav_oe(m_dav_oe), .nrfd_oe(m_nrfd_oe),
    .ndac_oe(m_ndac_oe), .atn_oe(m_atn_oe));

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (meas_trig === 1'b1)
      trig_cnt++;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // switches 4..8 weigh 16..1 and count when off
  function automatic logic [7:0] sw_for(logic [4:0] a);
    return {~a[0], ~a[1], ~a[2], ~a[3], ~a[4], 3'b001};
  endfunction : sw_for

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  // request held until the rising edge that sees waitrequest low; only the watchdog ends a wait
  task av(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] rq);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  task cmd(input logic [7:0] c);
    ctl.send(1'b1, c);
    repeat (3) @(posedge core_clk);
  endtask : cmd

  task press();
    @(posedge core_clk);
    btn_press <= 1'b1;
    @(posedge core_clk);
    btn_press <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : press

  task reset_to(input logic [7:0] s);
    @(posedge core_clk);
    arst_n <= 1'b0;
    sw_on <= s;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : reset_to

  task end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (30000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    addr = 5'(xs() % 31 + 1);
    reset_to(sw_for(addr));
    av(0, 5'h04, 0, q);
    chk("stat", {21'h0, addr, 6'h01}, q & 32'h7FF);
    av(0, 5'h18, 0, q);
    chk("unmapped", 32'h0, q);
    ren_n <= 1'b0;
    cmd(8'h20 | addr);
    chk("listen", 1, ind_listen);
    chk("remote", 1, ind_remote);
    repeat (3)
    begin
      b = 8'(xs());
      ctl.send(1'b0, b);
      av(0, 5'h0C, 0, q);
      chk("rx", {22'h0, 2'b10, b}, q & 32'h3FF);
    end
    cmd(8'h11);
    chk("lockout", 1, ind_lockout);
    press();
    av(0, 5'h10, 0, q);
    chk("locked press", 0, q[2]);
    cmd(8'h01);
    chk("gtl remote", 0, ind_remote);
    chk("gtl lockout", 1, ind_lockout);
    ren_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("ren off", 0, ind_lockout);
    press();
    av(0, 5'h10, 0, q);
    chk("press", 1, q[2]);
    av(1, 5'h10, 32'h0000_000F, q);
    clk_en <= 1'b0;
    press();
    clk_en <= 1'b1;
    av(0, 5'h10, 0, q);
    chk("frozen press", 0, q[2]);
    cmd(8'h08);
    chk("get off", 0, trig_cnt);
    av(1, 5'h00, 32'h0000_0001, q);
    cmd(8'h08);
    chk("get on", 1, trig_cnt);
    cmd(8'h14);
    av(0, 5'h00, 0, q);
    chk("dcl ctrl", 0, q);
    av(0, 5'h10, 0, q);
    chk("dcl evt", 2'b11, q[1:0]);
    cmd(8'h3F);
    chk("unlisten", 0, ind_listen);
    cmd(8'h40 | addr);
    b = 8'(xs());
    av(1, 5'h08, {23'h0, 1'b1, b}, q);
    chk("talk", 1, ind_talk);
    ctl.recv(xs() % 8, rb, e);
    chk("tx byte", b, rb);
    chk("tx eoi", 1, e);
    cmd(8'h5F);
    av(0, 5'h04, 0, q);
    chk("untalk", 0, q[1]);
    av(1, 5'h08, 32'h0000_00A5, q);
    ctl.release_atn();
    repeat (100) @(posedge core_clk);
    chk("silent", 1, dav);
    av(1, 5'h14, 32'h0000_0040, q);
    repeat (3) @(posedge core_clk);
    chk("srq", 0, srq);
    chk("pin level", 0, {dio_o, dav_o, nrfd_o, ndac_o, eoi_o, srq_o});
    cmd(8'h18);
    cmd(8'h40 | addr);
    ctl.recv(1, rb, e);
    chk("poll byte", 8'h40, rb);
    chk("poll eoi", 0, e);
    chk("srq off", 1, srq);
    cmd(8'h19);
    cmd(8'h20 | addr);
    ifc_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    ifc_n <= 1'b1;
    av(0, 5'h04, 0, q);
    chk("ifc", 0, q[3:1]);
    av(0, 5'h10, 0, q);
    chk("ifc evt", 1, q[3]);
    reset_to({sw_for(addr)} & 8'hFE);
    chk("to talk", 1, ind_talk);
    press();
    chk("to trig", 2, trig_cnt);
    b = 8'(xs());
    av(1, 5'h08, {23'h0, 1'b1, b}, q);
    ctl.recv(0, rb, e);
    chk("to byte", b, rb);
    repeat (3) @(posedge core_clk);
    chk("to blink", 1, ind_listen);
    repeat (40) @(posedge core_clk);
    chk("to rearm", 0, ind_listen);
    av(0, 5'h04, 0, q);
    chk("to idle", 0, q[12]);
    end_of_test();
  end
endmodule : gip_port_bench
